/* File: core/charge_time_pkg.sv */
// package: register map, field positions and shared types of the
// charge time unit; assumes a 32-bit axi4-lite register bus
package charge_time_pkg;

    localparam logic [7:0] measure_control_one_offset = 8'h00;
    localparam logic [7:0] edge_control_two_offset = 8'h04;
    localparam logic [7:0] current_source_control_offset = 8'h08;
    localparam logic [7:0] event_status_offset = 8'h0c;
    localparam logic [7:0] event_mask_offset = 8'h10;

    localparam logic [15:0] measure_control_one_reset = 16'h0000;
    localparam logic [15:0] edge_control_two_reset = 16'h0000;
    localparam logic [15:0] current_source_control_reset = 16'h0000;

    // measure_control_one fields
    localparam int unit_enable_bit = 15;
    localparam int idle_stop_select_bit = 13;
    localparam int delay_generation_enable_bit = 12;
    localparam int edge_accept_enable_bit = 11;
    localparam int edge_order_enable_bit = 10;
    localparam int current_discharge_enable_bit = 9;
    localparam int trigger_output_enable_bit = 8;
    localparam logic [15:0] measure_control_one_mask = 16'hbf00;

    // edge_control_two fields
    localparam int first_edge_sampling_mode_bit = 15;
    localparam int first_edge_polarity_bit = 14;
    localparam int first_edge_source_lsb = 10;
    localparam int second_edge_flag_bit = 9;
    localparam int first_edge_flag_bit = 8;
    localparam int second_edge_sampling_mode_bit = 7;
    localparam int second_edge_polarity_bit = 6;
    localparam int second_edge_source_lsb = 2;
    localparam logic [15:0] edge_control_two_mask = 16'hfffc;

    // current_source_control fields
    localparam int current_trim_lsb = 10;
    localparam int current_range_lsb = 8;
    localparam logic [15:0] current_source_control_mask = 16'hff00;

    // event status / mask layout
    localparam int event_first_bit = 0;
    localparam int event_second_bit = 1;
    localparam logic [1:0] event_reset = 2'h0;

    // edge source codes (shared by both edges)
    localparam logic [3:0] source_pin_one = 4'h3;
    localparam logic [3:0] source_pin_two = 4'h2;
    localparam logic [3:0] source_peripheral_a = 4'h1;
    localparam logic [3:0] source_peripheral_b = 4'h0;

    localparam logic [1:0] axi_resp_okay = 2'h0;
    localparam logic [1:0] axi_resp_slverr = 2'h2;

    // four candidate sources of one edge, per code
    typedef struct packed {
        logic pin_one;
        logic pin_two;
        logic periph_a;
        logic periph_b;
    } edge_sources_t;

    // analog-facing controls
    typedef struct packed {
        logic source_on;
        logic discharge_on;
        logic [5:0] trim;
        logic [1:0] range;
        logic delay_generation;
        logic idle_stop;
    } analog_control_t;

endpackage

/* File: core/edge_detect.sv */
// edge input conditioning for one edge channel: source select, two-flop
// synchroniser, polarity and edge/level sampling
// assumes sources are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module edge_detect
    import charge_time_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire edge_sources_t sources,
    input wire logic [3:0] source_select,
    input wire logic polarity,
    input wire logic edge_mode,
    output logic hit
);
    logic raw;
    edge_sources_t sync1_reg;
    edge_sources_t sync2_reg;
    logic last_reg;
    logic active;

    // sources crossed first; reserved codes 1xxx and 01xx select nothing
    always_comb begin
        raw = 1'b0;
        if (source_select == source_pin_one) begin
            raw = sync2_reg.pin_one;
        end else if (source_select == source_pin_two) begin
            raw = sync2_reg.pin_two;
        end else if (source_select == source_peripheral_a) begin
            raw = sync2_reg.periph_a;
        end else if (source_select == source_peripheral_b) begin
            raw = sync2_reg.periph_b;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            last_reg <= 1'b0;
        end else begin
            sync1_reg <= sources;
            sync2_reg <= sync1_reg;
            last_reg <= raw;
        end
    end

    // positive polarity: high level / rising edge; else low / falling
    assign active = polarity ? raw : ~raw;
    assign hit = edge_mode ? (active & ~(polarity ? last_reg : ~last_reg))
                           : active;
endmodule
`default_nettype wire

/* File: core/charge_time_unit.sv */
// charge time unit control block: axi4-lite registers, edge sequencing,
// current source, discharge and trigger controls, event interrupt
// assumes one clock aclk (200 mhz) and synchronous active-low reset
//
// Operation
// R1: unit acts only while unit_enable is set, idle when clear
// R2: software routes delay generation signals to a remappable pin first
// R3: with order enable, second edge accepted only after first edge
// R4: software discharges converter capacitor before each measurement
// R5: discharge sink connects only while discharge bit and sampling
// R6: trigger output driven only while trigger control bit is set
// R7: sampling-mode bits 15 and 7: one edge, zero level
// R8: polarity bits 14 and 6: one positive, zero negative
// R9: four-bit source selects; reserved codes select nothing
// R10: six-bit signed trim adjusts nominal current in 2% steps
// R11: temperature sensing uses range 11, hundred times base current
// R12: hardware sets edge flags; software writes also control edges
// R13: with edge enable clear, inputs ignored and flags unchanged
`timescale 1ns/1ps
`default_nettype none
module charge_time_unit
    import charge_time_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire edge_sources_t first_edge_sources,
    input wire edge_sources_t second_edge_sources,
    input wire logic converter_sampling,
    output analog_control_t analog_control,
    output logic discharge_sink_connect,
    output logic trigger_out,
    output logic trigger_out_enable,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // register file state

    logic [15:0] measure_control_one_reg;
    logic [15:0] edge_control_two_reg;
    logic [15:0] current_source_control_reg;
    logic [1:0] event_status_reg;
    logic [1:0] event_mask_reg;
    logic first_flag_reg;
    logic second_flag_reg;

    logic [7:0] aw_addr_reg;
    logic aw_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic w_held_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    logic do_write;
    logic do_read;
    logic [15:0] wr_half;

    // merge low half of write data with the old value by byte strobes
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [15:0] data,
                                            input logic [3:0] strb,
                                            input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) begin
            v[7:0] = data[7:0];
        end
        if (strb[1]) begin
            v[15:8] = data[15:8];
        end
        return v & mask;
    endfunction

    function automatic logic is_mapped(input logic [7:0] addr);
        return addr == measure_control_one_offset ||
               addr == edge_control_two_offset ||
               addr == current_source_control_offset ||
               addr == event_status_offset ||
               addr == event_mask_offset;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // axi4-lite write channel: address and data taken in either order

    assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
    assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    assign wr_half = w_data_reg[15:0];
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= axi_resp_okay;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(aw_addr_reg) ? axi_resp_okay
                                                : axi_resp_slverr;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            measure_control_one_reg <= measure_control_one_reset;
            current_source_control_reg <= current_source_control_reset;
            edge_control_two_reg <= edge_control_two_reset;
            event_mask_reg <= event_reset;
        end else if (do_write) begin
            if (aw_addr_reg == measure_control_one_offset) begin
                measure_control_one_reg <= merge16(measure_control_one_reg,
                    wr_half, w_strb_reg, measure_control_one_mask);
            end else if (aw_addr_reg == edge_control_two_offset) begin
                edge_control_two_reg <= merge16(edge_control_two_reg,
                    wr_half, w_strb_reg, edge_control_two_mask);
            end else if (aw_addr_reg == current_source_control_offset) begin
                current_source_control_reg <= merge16(
                    current_source_control_reg, wr_half, w_strb_reg,
                    current_source_control_mask);
            end else if (aw_addr_reg == event_mask_offset) begin
                if (w_strb_reg[0]) begin
                    event_mask_reg <= w_data_reg[1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // edge detection and sequencing

    logic unit_on;
    logic edges_on;
    logic order_on;
    logic first_hit;
    logic second_hit;
    logic first_take;
    logic second_take;
    logic flag_write;
    logic [15:0] flag_written;

    assign unit_on = measure_control_one_reg[unit_enable_bit]; // see R1
    assign edges_on = unit_on &
        measure_control_one_reg[edge_accept_enable_bit];
    assign order_on = measure_control_one_reg[edge_order_enable_bit];

    edge_detect first_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .sources(first_edge_sources),
        .source_select(edge_control_two_reg[first_edge_source_lsb +: 4]),
        .polarity(edge_control_two_reg[first_edge_polarity_bit]),
        .edge_mode(edge_control_two_reg[first_edge_sampling_mode_bit]),
        .hit(first_hit)
    ); // see R7 R8 R9

    edge_detect second_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .sources(second_edge_sources),
        .source_select(edge_control_two_reg[second_edge_source_lsb +: 4]),
        .polarity(edge_control_two_reg[second_edge_polarity_bit]),
        .edge_mode(edge_control_two_reg[second_edge_sampling_mode_bit]),
        .hit(second_hit)
    ); // see R7 R8 R9

    assign first_take = edges_on & first_hit; // see R13
    // in order mode the second edge needs the first already recorded
    assign second_take = edges_on & second_hit &
        (~order_on | first_flag_reg); // see R3 R13

    assign flag_write = do_write && aw_addr_reg == edge_control_two_offset;
    assign flag_written = merge16(edge_control_two_reg, wr_half,
        w_strb_reg, 16'hffff);

    // software writes steer the edges; a hardware edge wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_flag_reg <= 1'b0;
        end else if (first_take) begin
            first_flag_reg <= 1'b1; // see R12
        end else if (flag_write) begin
            first_flag_reg <= flag_written[first_edge_flag_bit]; // see R12
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            second_flag_reg <= 1'b0;
        end else if (second_take) begin
            second_flag_reg <= 1'b1; // see R12
        end else if (flag_write) begin
            second_flag_reg <= flag_written[second_edge_flag_bit];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // analog controls: current flows between first and second edge

    logic [15:0] edge_control_two_view;

    always_comb begin
        edge_control_two_view = edge_control_two_reg;
        edge_control_two_view[first_edge_flag_bit] = first_flag_reg;
        edge_control_two_view[second_edge_flag_bit] = second_flag_reg;
    end

    // trim and range are passed as codes; the analog source scales itself
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_control <= '0;
            discharge_sink_connect <= 1'b0;
            trigger_out <= 1'b0;
            trigger_out_enable <= 1'b0;
        end else begin
            analog_control.source_on <= unit_on &
                first_flag_reg & ~second_flag_reg; // see R1 R12
            analog_control.discharge_on <= unit_on &
                measure_control_one_reg[current_discharge_enable_bit];
            analog_control.trim <=
                current_source_control_reg[current_trim_lsb +: 6]; // see R10
            analog_control.range <=
                current_source_control_reg[current_range_lsb +: 2];
            analog_control.delay_generation <= unit_on &
                measure_control_one_reg[delay_generation_enable_bit];
            analog_control.idle_stop <=
                measure_control_one_reg[idle_stop_select_bit];
            discharge_sink_connect <= unit_on & converter_sampling &
                measure_control_one_reg[current_discharge_enable_bit];
                // see R5
            trigger_out_enable <= unit_on &
                measure_control_one_reg[trigger_output_enable_bit]; // see R6
            trigger_out <= unit_on &
                measure_control_one_reg[trigger_output_enable_bit] &
                second_flag_reg; // see R6
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event status, mask and interrupt; a read of status clears it

    logic status_read;

    assign status_read = do_read &&
        s_axi_araddr[7:2] == event_status_offset[7:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_status_reg <= event_reset;
        end else begin
            // new events win over the read-clear in the same cycle
            event_status_reg <=
                (status_read ? 2'b00 : event_status_reg) |
                {second_take, first_take};
        end
    end

    assign irq = |(event_status_reg & event_mask_reg);

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read channel: one cycle from address to data
    assign s_axi_arready = ~rvalid_reg;
    assign do_read = s_axi_arvalid & ~rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= axi_resp_okay;
        end else if (do_read) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= axi_resp_okay;
            rdata_reg <= 32'h0000_0000;
            if (s_axi_araddr[7:2] == measure_control_one_offset[7:2]) begin
                rdata_reg <= {16'h0000, measure_control_one_reg};
            end else if (s_axi_araddr[7:2] ==
                         edge_control_two_offset[7:2]) begin
                rdata_reg <= {16'h0000, edge_control_two_view};
            end else if (s_axi_araddr[7:2] ==
                         current_source_control_offset[7:2]) begin
                rdata_reg <= {16'h0000, current_source_control_reg};
            end else if (s_axi_araddr[7:2] == event_status_offset[7:2]) begin
                rdata_reg <= {30'h0000_0000, event_status_reg};
            end else if (s_axi_araddr[7:2] == event_mask_offset[7:2]) begin
                rdata_reg <= {30'h0000_0000, event_mask_reg};
            end else begin
                rresp_reg <= axi_resp_slverr;
            end
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: tb/edge_partner.sv */
// partner model: edge sources and converter sampling facing the unit
// assumes the bench moves its commands right after rising edges
`timescale 1ns/1ps
`default_nettype none
module edge_partner
    import charge_time_pkg::*;
(
    input wire logic aclk,
    input wire logic [3:0] lvl_a,
    input wire logic [3:0] lvl_b,
    input wire logic samp,
    output wire edge_sources_t first_edge_sources,
    output wire edge_sources_t second_edge_sources,
    output logic converter_sampling
);
////////////////////////////////////////////////////////////
    // sources are not tied to aclk, so they move mid-cycle
    assign #2 first_edge_sources = edge_sources_t'(lvl_a);
    assign #2 second_edge_sources = edge_sources_t'(lvl_b);
    // sampling stays on as long as asked, so discharge can reach
    always_ff @(posedge aclk) begin
        converter_sampling <= samp;
    end
endmodule
`default_nettype wire

/* File: tb/charge_time_unit_monitor.sv */
// checker: bus handshake, trigger and discharge relations
// assumes it is bound to the unit and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module charge_time_unit_monitor
    import charge_time_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic converter_sampling,
    input wire analog_control_t analog_control,
    input wire logic discharge_sink_connect,
    input wire logic trigger_out,
    input wire logic trigger_out_enable
);
////////////////////////////////////////////////////////////
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_resp_done;
        s_axi_bvalid && s_axi_bready;
    endsequence
////////////////////////////////////////////////////////////
    a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_read_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_resp_reopens: assert property (s_resp_done
        |=> !s_axi_bvalid && s_axi_awready)
        else $error("bus not reopened after response");
    a_trig_gated: assert property (
        trigger_out |-> trigger_out_enable)
        else $error("trigger out without enable");
    a_trig_by_write: assert property (
        $rose(trigger_out_enable) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("trigger enable moved without write");
    a_sink_sampling: assert property (
        discharge_sink_connect |-> $past(converter_sampling))
        else $error("sink connected while not sampling");
    a_sink_bit: assert property (
        discharge_sink_connect |-> analog_control.discharge_on)
        else $error("sink connected without discharge bit");
endmodule
bind charge_time_unit charge_time_unit_monitor charge_time_unit_monitor_inst (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .converter_sampling, .analog_control,
    .discharge_sink_connect, .trigger_out, .trigger_out_enable);
`default_nettype wire

/* File: tb/charge_time_unit_tb.sv */
// testbench: register sequences against the charge time unit
// assumes the partner model supplies edge sources and sampling
`timescale 1ns/1ps
`default_nettype none
module charge_time_unit_tb
    import charge_time_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, samp;
    logic s_axi_arvalid, s_axi_rready, converter_sampling;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb, lvl_a, lvl_b;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, discharge_sink_connect, trigger_out;
    logic trigger_out_enable, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    edge_sources_t first_edge_sources, second_edge_sources;
    analog_control_t analog_control;
    int n_errors = 0;
    int samples_checked = 0;
    logic [7:0] offs [3] = '{8'h00, 8'h04, 8'h08};
    logic [15:0] msks [3] = '{16'hbf00, 16'hfffc, 16'hff00};
////////////////////////////////////////////////////////////
    always #2.5 aclk = ~aclk;
    charge_time_unit charge_time_unit_inst (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .first_edge_sources, .second_edge_sources,
        .converter_sampling, .analog_control, .discharge_sink_connect,
        .trigger_out, .trigger_out_enable, .irq);
    edge_partner edge_partner_inst (.aclk, .lvl_a, .lvl_b, .samp,
        .first_edge_sources, .second_edge_sources, .converter_sampling);
////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // both channels offered together; each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("rdata", e, rv);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////
    initial begin
        cyc(20000);
        n_errors++;
        conclude;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, samp} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {lvl_a, lvl_b} = 8'h0;
        s_axi_wstrb = 4'hf;
        cyc(12);
        aresetn <= 1'b1;
        cyc(1);
        for (int i = 0; i < 5; i++) rdc(8'(i * 4), 32'h0);
        for (int i = 0; i < 3; i++) begin
            wr(offs[i], 32'hffff_ffff);
            rdc(offs[i], {16'h0, msks[i]});
        end
        chk("analog", 12'h7ff, analog_control);
        wr(8'h08, 32'h7f00);
        chk("trim", 6'h1f, analog_control.trim);
        chk("range", 2'h3, analog_control.range);
        cyc(2);
        chk("trig", 1'b1, trigger_out);
        wr(8'h14, 32'h1);
        chk("bresp", 2'h2, rr);
        rdc(8'h14, 32'h0);
        chk("rresp", 2'h2, rr);
        wr(8'h00, 32'h0);
        cyc(2);
        chk("trig_en", 1'b0, trigger_out_enable);
        // edges arrive while accepting is off: flags must not move
        lvl_b <= 4'h4;
        wr(8'h04, 32'hcc88);
        rd(8'h0c);
        wr(8'h10, 32'h3);
        wr(8'h00, 32'h8000);
        lvl_a <= 4'h8;
        cyc(8);
        rdc(8'h04, 32'hcc88);
        wr(8'h00, 32'h8c00);
        lvl_a <= 4'h0;
        lvl_b <= 4'h0;
        cyc(8);
        rdc(8'h04, 32'hcc88);
        chk("irq", 1'b0, irq);
        lvl_a <= 4'h8;
        lvl_b <= 4'h4;
        cyc(8);
        chk("src_on", 1'b1, analog_control.source_on);
        chk("irq", 1'b1, irq);
        lvl_b <= 4'h0;
        cyc(8);
        rdc(8'h04, 32'hcf88);
        chk("trig_en", 1'b0, trigger_out_enable);
        wr(8'h00, 32'h8d00);
        cyc(2);
        chk("trig", 1'b1, trigger_out);
        rdc(8'h0c, 32'h3);
        rdc(8'h0c, 32'h0);
        cyc(2);
        chk("irq", 1'b0, irq);
        wr(8'h00, 32'h0d00);
        cyc(2);
        chk("trig_en", 1'b0, trigger_out_enable);
        // level sensing sets the flag again while the input stays high
        wr(8'h00, 32'h8800);
        wr(8'h04, 32'h4c88);
        cyc(8);
        wr(8'h04, 32'h4c88);
        cyc(8);
        rdc(8'h04, 32'h4d88);
        lvl_a <= 4'h0;
        cyc(8);
        wr(8'h04, 32'h4c88);
        cyc(8);
        rdc(8'h04, 32'h4c88);
        rd(8'h0c);
        wr(8'h10, 32'h0);
        for (int c = 0; c < 5; c++) begin
            lvl_a <= 4'h0;
            cyc(6);
            wr(8'h04, 32'hc088 | (32'(c) << 10));
            lvl_a <= (c < 4) ? 4'(1 << c) : 4'hf;
            cyc(8);
            rd(8'h04);
            chk("flag1", (c < 4), rv[8]);
        end
        chk("irq", 1'b0, irq);
        wr(8'h10, 32'h1);
        cyc(2);
        chk("irq", 1'b1, irq);
        rdc(8'h0c, 32'h1);
        cyc(2);
        chk("irq", 1'b0, irq);
        // discharge is reached only while the converter samples
        wr(8'h00, 32'h8200);
        cyc(4);
        chk("sink", 1'b0, discharge_sink_connect);
        samp <= 1'b1;
        cyc(4);
        chk("sink", 1'b1, discharge_sink_connect);
        samp <= 1'b0;
        cyc(4);
        chk("sink", 1'b0, discharge_sink_connect);
        conclude;
    end
endmodule
`default_nettype wire
